// file: dv/eep_bus_master.sv
// Two-wire bus master model: owns the bus clock, pulls the data line low.
// Assumes a pull-up in the bench; bus period 20 clk cycles.
`timescale 1ns/1ns
module eep_bus_master (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_pull
);
    // ------------
    // Bus phases
    // ------------
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic step(input logic pull, input logic hi);
        sda_pull = pull;
        scl = hi;
        repeat (5) @(negedge clk);
    endtask
    task automatic bitc(input logic b, output logic r);
        step(!b, 1'b0);
        step(!b, 1'b1);
        r = sda_in;
        step(!b, 1'b1);
        step(!b, 1'b0);
    endtask
    // Also a repeated start
    task automatic start();
        step(1'b0, scl);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic stop();
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitc(b[i], r);
        end
        bitc(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitc(1'b1, r);
            b[i] = r;
        end
        bitc(!mack, r);
    endtask
endmodule

// file: dv/eep_serial_slave_tb_top.sv
// Self-checking bench for the two-wire EEPROM slave.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
module eep_serial_slave_tb_top;
    localparam int WR_CYCLES = 600;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic write_protect = 1'b0;
    logic sel_lo = 1'b0;
    logic sel_hi = 1'b0;
    logic scl, sda_pull, sda_o, sda_oe, write_busy, ack;
    logic [7:0] d1, d2, rb;
    logic [8:0] ctr = 9'h000;
    logic [7:0] mem [512] = '{default: 8'h00};
    logic [7:0] mask [3] = '{8'h80, 8'h08, 8'h04};
    int seed = 32'h719b69c6;
    int bad_count = 0;
    int n_compared = 0;
    wire sda = !(sda_pull || (sda_oe && !sda_o));
    always #4 clk = !clk;
    eep_serial_slave #(.WR_CYCLES(WR_CYCLES)) dut (.clk(clk), .rstn(rstn), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .write_protect(write_protect),
        .device_select_pin_low(sel_lo), .device_select_pin_high(sel_hi),
        .write_busy(write_busy));
    eep_bus_master u_m (.clk(clk), .sda_in(sda), .scl(scl), .sda_pull(sda_pull));
    // ------------
    // Bench tasks
    // ------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] sla(input logic rw, input logic blk);
        return {eep_pkg::DEV_TYPE, sel_hi, sel_lo, blk, rw};
    endfunction
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic ok;
        ok = !(write_protect && a[8]);
        u_m.start();
        u_m.wbyte(sla(1'b0, a[8]), ack);
        chk(ack, 1'b1);
        u_m.wbyte(a[7:0], ack);
        chk(ack, 1'b1);
        u_m.wbyte(d, ack);
        chk(ack, ok);
        u_m.stop();
        if (ok) begin
            mem[a] = d;
            ctr = a + 9'h001;
        end
    endtask
    task automatic poll(input logic blk);
        for (int k = 0; k < 20; k++) begin
            u_m.start();
            u_m.wbyte(sla(1'b0, blk), ack);
            if (k == 0) chk(ack, 1'b0);
            if (ack === 1'b1) break;
            u_m.stop();
        end
        chk(ack, 1'b1);
    endtask
    task automatic rd(input logic [8:0] a, input int n, input logic polled);
        if (!polled) begin
            u_m.start();
            u_m.wbyte(sla(1'b0, a[8]), ack);
        end
        u_m.wbyte(a[7:0], ack);
        chk(ack, 1'b1);
        u_m.start();
        u_m.wbyte(sla(1'b1, a[8]), ack);
        chk(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_m.rbyte(i < n - 1, rb);
            chk(rb, mem[9'(a + i)]);
        end
        u_m.stop();
        ctr = 9'(a + n);
    endtask
    task automatic cur_rd();
        u_m.start();
        u_m.wbyte(sla(1'b1, 1'b0), ack);
        chk(ack, 1'b1);
        u_m.rbyte(1'b0, rb);
        chk(rb, mem[ctr]);
        u_m.stop();
        ctr = ctr + 9'h001;
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    initial begin
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        {sel_hi, sel_lo} = 2'($random(seed));
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        wr(9'h1a5, d1);
        chk(write_busy, 1'b1);
        poll(1'b1);
        u_m.stop();
        wr(9'h1a4, d2);
        poll(1'b1);
        u_m.stop();
        cur_rd();
        $display("test write, poll and current read done");
        rd(9'h1a4, 2, 1'b0);
        wr(9'h1ff, ~d1);
        poll(1'b1);
        u_m.stop();
        $display("test random read done");
        write_protect = 1'b1;
        wr(9'h1a5, ~d1);
        repeat (20) @(negedge clk);
        chk(write_busy, 1'b0);
        rd(9'h1a5, 1, 1'b0);
        wr(9'h000, ~d2);
        poll(1'b1);
        rd(9'h1fe, 4, 1'b1);
        $display("test protect and wrap done");
        for (int i = 0; i < 3; i++) begin
            u_m.start();
            u_m.wbyte(sla(1'b0, 1'b0) ^ mask[i], ack);
            chk(ack, 1'b0);
            u_m.stop();
        end
        $display("test address refusal done");
        finish_test();
    end
endmodule
bind eep_serial_slave eep_sva #(.WR_CYCLES(WR_CYCLES)) u_sva (.clk(clk), .rstn(rstn),
    .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .write_protect(write_protect), .device_select_pin_low(device_select_pin_low),
    .device_select_pin_high(device_select_pin_high), .write_busy(write_busy));

// file: dv/eep_sva.sv
// Port checks for the two-wire EEPROM slave.
// Assumes a bus clock far slower than clk and a master that idles high.
`timescale 1ns/1ns
module eep_sva #(
    parameter int WR_CYCLES = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic device_select_pin_low,
    input wire logic device_select_pin_high,
    input wire logic write_busy
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ------------
    // Bus trackers
    // ------------
    logic scl_q, sda_q, idle_q, stop_now, start_now;
    int busy_n_q, since_stop_q;
    assign stop_now = scl_q && scl && !sda_q && sda_i;
    assign start_now = scl_q && scl && sda_q && !sda_i;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            idle_q <= 1'b1;
            busy_n_q <= 0;
            since_stop_q <= 1000;
        end else begin
            scl_q <= scl;
            sda_q <= sda_i;
            idle_q <= stop_now || (idle_q && !start_now);
            busy_n_q <= write_busy ? busy_n_q + 1 : 0;
            since_stop_q <= stop_now ? 0 : (since_stop_q < 1000 ? since_stop_q + 1 : 1000);
        end
    end
    sequence s_scl_high;
        ##[1:20] scl;
    endsequence
    sequence s_busy_run;
        write_busy [*8];
    endsequence
    a_busy_quiet: assert property (write_busy |-> !sda_oe)
        else $error("data line driven during write cycle");
    a_drive_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("data drive changed while bus clock high");
    a_slot_held: assert property ($rose(sda_oe) |-> sda_oe throughout s_scl_high)
        else $error("data drive dropped before bus clock high");
    a_busy_length: assert property ($fell(write_busy) |-> busy_n_q == WR_CYCLES)
        else $error("write cycle length wrong");
    a_busy_cause: assert property ($rose(write_busy) |-> since_stop_q <= 12)
        else $error("write cycle started without stop");
    a_busy_holds: assert property ($rose(write_busy) |-> s_busy_run)
        else $error("write cycle too short");
    a_idle_release: assert property (idle_q |-> !sda_oe)
        else $error("data line driven between frames");
    a_open_drain: assert property (sda_oe |-> !sda_o)
        else $error("data line driven high");
endmodule

// file: pkg/eep_pkg.sv
// Constants, field positions and state codes of the two-wire EEPROM slave.
// Assumes a 125 MHz system clock that oversamples the bus pins.
package eep_pkg;

    // Identity of the device type nibble; value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'h5;

    // Memory shape
    localparam int ADDR_W = 9;
    localparam int MEM_BYTES = 512;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_W = 4;

    // Slave address byte fields
    localparam int SA_RW_BIT = 0;
    localparam int SA_BLK_BIT = 1;
    localparam int SA_PIN_LO_BIT = 2;
    localparam int SA_PIN_HI_BIT = 3;
    localparam int SA_TYPE_LSB = 4;

    // Bits per byte on the wire
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Synchronised pin vector positions
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_WP = 2;
    localparam int PIN_SEL_LO = 3;
    localparam int PIN_SEL_HI = 4;
    localparam int PIN_COUNT = 5;

    // Self-timed write cycle
    localparam int CLK_PERIOD_NS = 8;
    localparam int WRITE_CYCLE_US = 5000;
    localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_WORD = 4'h3,
        ST_WORD_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RACK = 4'h8
    } eep_state_t;

endpackage

// file: rtl/eep_pin_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ns
module eep_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } eep_sync_t;

    eep_sync_t s_q;
    eep_sync_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = pin_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_sync = s_q.stable;

endmodule

// file: rtl/eep_serial_slave.sv
// Two-wire serial EEPROM slave: addressing, writes, polling, protect, reads.
// Assumes the bus pins are asynchronous and oversampled by clk; the
// open-drain data pin is resolved outside from sda_o and sda_oe.
`timescale 1ns/1ns

// Summary of operation
// - After a write stop the internal cycle starts; polling may follow at once.
// - While the write cycle runs, a polling address gets no acknowledge.
// - After the write cycle ends, the polling address is acknowledged.
// - With protect pin high, the upper half is never programmed; reads allowed.
// - Protected writes still acknowledge slave address and byte address.
// - Protected writes get no acknowledge after the first data byte.
// - A protected write starts no program cycle at stop.
// - Address counter holds last accessed address plus one, rolling within the page after writes; serves current reads.
// - A matching read address is acknowledged, then the counter byte goes out.
// - Single read: master skips acknowledge and stops; device stops sending.
// - Repeated start with read address after it returns the loaded byte.
// - Sequential read starts as current-address or random read.
// - Each master acknowledge makes the device send the byte at the next address.
// - Missing master acknowledge or stop ends the read.
// - Read counter increments across all word address bits.
// - After the last location the read counter wraps to the first.
// - Lowest select bit picks the page block on writes only; other two match select pins.
// - Second write byte is the eight-bit word address within the block.
// - During the write cycle the device ignores all requests.
// - Upper nibble of slave address must match the device type.
module eep_serial_slave #(
    parameter int WR_CYCLES = eep_pkg::WRITE_CYCLE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic write_protect,
    input wire logic device_select_pin_low,
    input wire logic device_select_pin_high,
    output logic write_busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        eep_pkg::eep_state_t st;
        logic scl_prev;
        logic sda_prev;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic is_read;
        logic sel_blk;
        logic [eep_pkg::ADDR_W-1:0] ctr;
        logic [eep_pkg::PAGE_BYTES-1:0][7:0] page_buf;
        logic [eep_pkg::PAGE_BYTES-1:0] page_vld;
        logic wr_armed;
        logic prot_hit;
        logic master_ack;
        logic sda_oe;
        logic sda_o;
        logic commit;
        logic [eep_pkg::MEM_BYTES-1:0][7:0] mem;
    } eep_core_t;

    eep_core_t s_q;
    eep_core_t s_d;

    logic [eep_pkg::PIN_COUNT-1:0] pins_async;
    logic [eep_pkg::PIN_COUNT-1:0] pins_s;
    logic busy;

    // ------------------------------------------------------------
    // Pin synchronisers and write timer
    // ------------------------------------------------------------
    always_comb begin
        pins_async = '0;
        pins_async[eep_pkg::PIN_SCL] = scl;
        pins_async[eep_pkg::PIN_SDA] = sda_i;
        pins_async[eep_pkg::PIN_WP] = write_protect;
        pins_async[eep_pkg::PIN_SEL_LO] = device_select_pin_low;
        pins_async[eep_pkg::PIN_SEL_HI] = device_select_pin_high;
    end

    eep_pin_sync #(
        .W(eep_pkg::PIN_COUNT)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in(pins_async),
        .pin_sync(pins_s)
    );

    eep_write_timer #(
        .CYCLES(WR_CYCLES)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .start(s_q.commit),
        .busy(busy)
    );

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic addr_match;
    logic byte_done;

    always_comb begin
        scl_s = pins_s[eep_pkg::PIN_SCL];
        sda_s = pins_s[eep_pkg::PIN_SDA];
        wp_s = pins_s[eep_pkg::PIN_WP];
        scl_rise = scl_s & ~s_q.scl_prev;
        scl_fall = ~scl_s & s_q.scl_prev;
        bus_start = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
        bus_stop = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;
        byte_done = scl_fall && (s_q.bit_cnt == eep_pkg::BITS_PER_BYTE);
        addr_match = (s_q.shreg[7:eep_pkg::SA_TYPE_LSB] == eep_pkg::DEV_TYPE)
            && (s_q.shreg[eep_pkg::SA_PIN_HI_BIT] == pins_s[eep_pkg::PIN_SEL_HI])
            && (s_q.shreg[eep_pkg::SA_PIN_LO_BIT] == pins_s[eep_pkg::PIN_SEL_LO])
            && !busy;
    end

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.commit = 1'b0;
        s_d.sda_o = 1'b0;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        if (bus_stop) begin
            s_d.st = eep_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
            // Program buffered bytes only for an unprotected, acked write
            if (s_q.wr_armed && !s_q.prot_hit && !busy) begin
                for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
                    if (s_q.page_vld[i]) begin
                        s_d.mem[{s_q.ctr[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W],
                            eep_pkg::PAGE_W'(i)}] = s_q.page_buf[i];
                    end
                end
                s_d.commit = 1'b1;
            end
            s_d.wr_armed = 1'b0;
            s_d.prot_hit = 1'b0;
            s_d.page_vld = '0;
        end else if (bus_start) begin
            s_d.st = eep_pkg::ST_ADDR;
            s_d.bit_cnt = '0;
            s_d.sda_oe = 1'b0;
            s_d.wr_armed = 1'b0;
            s_d.prot_hit = 1'b0;
            s_d.page_vld = '0;
        end else begin
            unique case (s_q.st)
                eep_pkg::ST_IDLE: begin
                    s_d.sda_oe = 1'b0;
                end
                eep_pkg::ST_ADDR, eep_pkg::ST_WORD, eep_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        s_d.shreg = {s_q.shreg[6:0], sda_s};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        s_d.bit_cnt = '0;
                        if (s_q.st == eep_pkg::ST_ADDR) begin
                            if (addr_match) begin
                                s_d.sda_oe = 1'b1;
                                s_d.is_read = s_q.shreg[eep_pkg::SA_RW_BIT];
                                s_d.sel_blk = s_q.shreg[eep_pkg::SA_BLK_BIT];
                                s_d.st = eep_pkg::ST_ADDR_ACK;
                            end else begin
                                s_d.st = eep_pkg::ST_IDLE;
                            end
                        end else if (s_q.st == eep_pkg::ST_WORD) begin
                            s_d.ctr = {s_q.sel_blk, s_q.shreg};
                            s_d.sda_oe = 1'b1;
                            s_d.st = eep_pkg::ST_WORD_ACK;
                        end else if (wp_s && s_q.ctr[eep_pkg::ADDR_W-1]) begin
                            s_d.prot_hit = 1'b1;
                            s_d.st = eep_pkg::ST_IDLE;
                        end else begin
                            s_d.page_buf[s_q.ctr[eep_pkg::PAGE_W-1:0]] = s_q.shreg;
                            s_d.page_vld[s_q.ctr[eep_pkg::PAGE_W-1:0]] = 1'b1;
                            // Page write rolls over inside its page
                            s_d.ctr[eep_pkg::PAGE_W-1:0] =
                                s_q.ctr[eep_pkg::PAGE_W-1:0] + 4'h1;
                            s_d.wr_armed = 1'b1;
                            s_d.sda_oe = 1'b1;
                            s_d.st = eep_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                eep_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        s_d.bit_cnt = '0;
                        if (s_q.is_read) begin
                            // First byte from the counter address
                            s_d.shreg = s_q.mem[s_q.ctr];
                            s_d.sda_oe = ~s_q.mem[s_q.ctr][7];
                            s_d.ctr = s_q.ctr + 9'h001;
                            s_d.st = eep_pkg::ST_RDATA;
                        end else begin
                            s_d.sda_oe = 1'b0;
                            s_d.st = eep_pkg::ST_WORD;
                        end
                    end
                end
                eep_pkg::ST_WORD_ACK, eep_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        s_d.sda_oe = 1'b0;
                        s_d.bit_cnt = '0;
                        s_d.st = eep_pkg::ST_WDATA;
                    end
                end
                eep_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        s_d.sda_oe = 1'b0;
                        s_d.st = eep_pkg::ST_RACK;
                    end else if (scl_fall) begin
                        s_d.shreg = {s_q.shreg[6:0], 1'b0};
                        s_d.sda_oe = ~s_q.shreg[6];
                    end
                end
                eep_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        s_d.master_ack = ~sda_s;
                    end else if (scl_fall) begin
                        s_d.bit_cnt = '0;
                        if (s_q.master_ack) begin
                            // Counter spans all nine bits and wraps
                            s_d.shreg = s_q.mem[s_q.ctr];
                            s_d.sda_oe = ~s_q.mem[s_q.ctr][7];
                            s_d.ctr = s_q.ctr + 9'h001;
                            s_d.st = eep_pkg::ST_RDATA;
                        end else begin
                            s_d.sda_oe = 1'b0;
                            s_d.st = eep_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    s_d.sda_oe = 1'b0;
                    s_d.st = eep_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_o = s_q.sda_o;
    assign sda_oe = s_q.sda_oe;
    assign write_busy = busy;

endmodule

// file: rtl/eep_write_timer.sv
// Busy timer for the self-timed internal write cycle.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ns
module eep_write_timer #(
    parameter int CYCLES = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    output logic busy
);

    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

    typedef struct packed {
        logic [CNT_W-1:0] remain;
        logic busy;
    } eep_timer_t;

    eep_timer_t s_q;
    eep_timer_t s_d;

    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.remain = LOAD;
            s_d.busy = 1'b1;
        end else if (s_q.remain > '0) begin
            s_d.remain = s_q.remain - 1'b1;
            s_d.busy = (s_q.remain > CNT_W'(1));
        end else begin
            s_d.busy = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;

endmodule
